/* File: design/adcp_pkg.sv */
// Package of constants and types for the converter output port block
package adcp_pkg;

  // ---------------------------------------------------------------
  // Widths and bus line positions
  // ---------------------------------------------------------------
  localparam int RES_W = 18;
  localparam int FIFO_DEPTH = 8;
  localparam int LINE_FMT = 0;
  localparam int LINE_WSEL = 1;
  localparam int LINE_BSEL = 2;
  localparam int LINE_LOW_WORD = 2;
  localparam int LINE_BYTE_LO = 10;
  localparam int LINE_BYTE_ZERO_TOP = 15;
  localparam int LINE_FIXED_LO = 14;
  localparam int RES_MSB = RES_W - 1;

  // ---------------------------------------------------------------
  // Bus drive patterns and reset values
  // ---------------------------------------------------------------
  localparam logic [RES_W-1:0] OE_NONE = 18'h00000;
  localparam logic [RES_W-1:0] OE_FIXED = 18'h3C000;
  localparam logic [RES_W-1:0] OE_ALL = 18'h3FFFF;
  localparam logic [RES_W-1:0] OE_WORD = 18'h3FFFC;
  localparam logic [RES_W-1:0] OE_BYTE = 18'h3FC00;
  localparam logic [RES_W-1:0] DATA_RESET = 18'h00000;

  // ---------------------------------------------------------------
  // Interface mode codes {interface_mode_sel_hi, interface_mode_sel_lo}
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCP_MODE_P18 = 2'b00,
    ADCP_MODE_P16 = 2'b01,
    ADCP_MODE_P8 = 2'b10,
    ADCP_MODE_SER = 2'b11
  } adcp_mode_t;

  // Byte select codes {word_select, byte_select}
  localparam logic [1:0] BYTE_HIGH = 2'b00;
  localparam logic [1:0] BYTE_MID = 2'b01;
  localparam logic [1:0] BYTE_LOW_A = 2'b10;
  localparam logic [1:0] BYTE_LOW_B = 2'b11;

  // ---------------------------------------------------------------
  // Conversion sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCP_ST_IDLE = 2'b00,
    ADCP_ST_CONV = 2'b01,
    ADCP_ST_PUSH = 2'b10,
    ADCP_ST_ACQ = 2'b11
  } adcp_state_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int CONV_TIME_NS = 1000;
  localparam int ACQ_TIME_NS = 250;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

endpackage : adcp_pkg

/* File: design/adcp_fifo.sv */
// Result FIFO with valid/ready on both sides, flip-flop storage
`timescale 1ns/100ps
`default_nettype none
module adcp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = DEPTH[PW:0];

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != DEPTH_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [PW-1:0] adcp_ptr_inc(input logic [PW-1:0] p);
    adcp_ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : adcp_ptr_inc

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= adcp_ptr_inc(wptr_reg);
      end
      if (pop) begin
        rptr_reg <= adcp_ptr_inc(rptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : adcp_fifo
`default_nettype wire

/* File: design/adcp_port.sv */
// Conversion control and parallel output port of the sampling converter
`timescale 1ns/100ps
`default_nettype none
module adcp_port
  import adcp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reset_in,
  input wire logic convert_start_n,
  input wire logic power_down_in,
  input wire logic ref_buffer_disable,
  input wire logic low_power_sel,
  input wire logic fast_mode_sel,
  input wire logic interface_mode_sel_lo,
  input wire logic interface_mode_sel_hi,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic serial_ext_clk_sel,
  input wire logic serial_ext_clk,
  input wire logic [RES_W-1:0] sample_code,
  input wire logic [RES_W-1:0] data_in,
  output logic [RES_W-1:0] data_out,
  output logic [RES_W-1:0] data_oe,
  output logic busy,
  output logic ref_buffer_enable,
  output logic serial_clk_gated,
  output logic serial_port_enable,
  output logic power_down_active
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  adcp_state_t state_reg;
  adcp_mode_t mode;
  logic [CNT_W-1:0] cnt_reg;
  logic [RES_W-1:0] held_reg;
  logic [RES_W-1:0] result_reg;
  logic convert_start_n_prev_reg;
  logic convert_start_n_fall;
  logic impulse_mode;
  logic start_ok;
  logic read_on;
  logic output_format_select;
  logic word_select;
  logic byte_select;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [RES_W-1:0] fifo_out_data;
  logic [RES_W-1:0] coded;
  logic [RES_W-1:0] bus_next;
  logic [RES_W-1:0] oe_next;
  logic busy_next;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Lines 0..2 turn into host inputs outside the 18-bit mode, except line 2 during 16-bit reads
  assign mode = adcp_mode_t'({interface_mode_sel_hi, interface_mode_sel_lo});
  assign output_format_select = data_in[LINE_FMT];
  assign word_select = data_in[LINE_WSEL];
  assign byte_select = data_in[LINE_BSEL];
  assign read_on = !cs_n && !rd_n;
  assign impulse_mode = low_power_sel && !fast_mode_sel;
  assign convert_start_n_fall = convert_start_n_prev_reg && !convert_start_n;
  assign start_ok = !power_down_in;

  // Two's complement differs from straight binary only in the sign bit
  function automatic logic [RES_W-1:0] adcp_code(
    input logic [RES_W-1:0] r,
    input adcp_mode_t m,
    input logic fmt
  );
    adcp_code = r;
    if (m != ADCP_MODE_P18 && !fmt) begin
      adcp_code[RES_MSB] = !r[RES_MSB];
    end
  endfunction : adcp_code

  assign coded = adcp_code(result_reg, mode, output_format_select);

  // ---------------------------------------------------------------
  // Convert start edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      convert_start_n_prev_reg <= 1'b1;
    end else if (reset_in) begin
      convert_start_n_prev_reg <= 1'b1;
    end else begin
      convert_start_n_prev_reg <= convert_start_n;
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  // The result only leaves PUSH when the FIFO takes it, so a full FIFO
  // stalls the converter rather than dropping a sample.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ADCP_ST_IDLE;
      cnt_reg <= CNT_ZERO;
    end else if (reset_in) begin
      state_reg <= ADCP_ST_IDLE;
      cnt_reg <= CNT_ZERO;
    end else begin
      unique case (state_reg)
        ADCP_ST_IDLE: begin
          if (convert_start_n_fall && start_ok) begin
            state_reg <= ADCP_ST_CONV;
            cnt_reg <= CNT_W'(CONV_CYCLES - 1);
          end
        end
        ADCP_ST_CONV: begin
          // Power-down does not cut a conversion short
          if (cnt_reg == CNT_ZERO) begin
            state_reg <= ADCP_ST_PUSH;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        ADCP_ST_PUSH: begin
          if (fifo_in_ready) begin
            if (impulse_mode) begin
              state_reg <= ADCP_ST_ACQ;
              cnt_reg <= CNT_W'(ACQ_CYCLES - 1);
            end else begin
              state_reg <= ADCP_ST_IDLE;
            end
          end
        end
        ADCP_ST_ACQ: begin
          if (cnt_reg != CNT_ZERO) begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end else if (!convert_start_n && start_ok) begin
            state_reg <= ADCP_ST_CONV;
            cnt_reg <= CNT_W'(CONV_CYCLES - 1);
          end else begin
            state_reg <= ADCP_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sample hold
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held_reg <= DATA_RESET;
    end else if (state_reg == ADCP_ST_IDLE && convert_start_n_fall && start_ok) begin
      held_reg <= sample_code;
    end else if (state_reg == ADCP_ST_ACQ && cnt_reg == CNT_ZERO &&
                 !convert_start_n && start_ok) begin
      held_reg <= sample_code;
    end
  end

  // ---------------------------------------------------------------
  // Result FIFO and output register
  // ---------------------------------------------------------------
  // The output register is only refilled between reads so the host
  // never sees the word change under an active read strobe.
  assign fifo_pop = fifo_out_valid && !read_on;

  adcp_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(reset_in),
    .in_data(held_reg),
    .in_valid(state_reg == ADCP_ST_PUSH),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_reg <= DATA_RESET;
    end else if (reset_in) begin
      result_reg <= DATA_RESET;
    end else if (fifo_pop) begin
      result_reg <= fifo_out_data;
    end
  end

  // ---------------------------------------------------------------
  // Busy
  // ---------------------------------------------------------------
  // Busy drops on the edge the FIFO accepts the result
  always_comb begin
    busy_next = 1'b0;
    if (state_reg == ADCP_ST_IDLE) begin
      busy_next = convert_start_n_fall && start_ok;
    end else if (state_reg == ADCP_ST_CONV) begin
      busy_next = 1'b1;
    end else if (state_reg == ADCP_ST_PUSH) begin
      busy_next = !fifo_in_ready;
    end else begin
      busy_next = cnt_reg == CNT_ZERO && !convert_start_n && start_ok;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else if (reset_in) begin
      busy <= 1'b0;
    end else begin
      busy <= busy_next;
    end
  end

  // ---------------------------------------------------------------
  // Bus data and drive enables
  // ---------------------------------------------------------------
  always_comb begin
    bus_next = DATA_RESET;
    oe_next = OE_FIXED;
    unique case (mode)
      ADCP_MODE_P18: begin
        bus_next = result_reg;
        if (read_on) begin
          oe_next = OE_ALL;
        end
      end
      ADCP_MODE_P16: begin
        if (!word_select) begin
          bus_next[RES_MSB:LINE_LOW_WORD] = coded[RES_MSB:LINE_LOW_WORD];
        end else begin
          bus_next[LINE_LOW_WORD+1:LINE_LOW_WORD] = coded[1:0];
        end
        if (read_on) begin
          oe_next = OE_WORD;
        end
      end
      ADCP_MODE_P8: begin
        unique case ({word_select, byte_select})
          BYTE_HIGH: bus_next[RES_MSB:LINE_BYTE_LO] = coded[17:10];
          BYTE_MID: bus_next[RES_MSB:LINE_BYTE_LO] = coded[9:2];
          BYTE_LOW_A: begin
            bus_next[LINE_BYTE_LO+1:LINE_BYTE_LO] = coded[1:0];
          end
          BYTE_LOW_B: begin
            bus_next[RES_MSB:LINE_BYTE_ZERO_TOP+1] = coded[1:0];
          end
        endcase
        if (read_on) begin
          oe_next = OE_BYTE;
        end
      end
      ADCP_MODE_SER: begin
        // Serial data leaves through the serial port, lines 14-17 stay low
        bus_next = DATA_RESET;
        oe_next = OE_FIXED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= DATA_RESET;
      data_oe <= OE_FIXED;
    end else begin
      data_out <= bus_next;
      data_oe <= oe_next;
    end
  end

  // ---------------------------------------------------------------
  // Serial hand-over, reference buffer, power state
  // ---------------------------------------------------------------
  // The gated clock is resampled, so it is only good for external
  // clocks well below half the system clock.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_clk_gated <= 1'b0;
      serial_port_enable <= 1'b0;
    end else begin
      serial_clk_gated <= serial_ext_clk && serial_ext_clk_sel &&
                          !cs_n && (mode == ADCP_MODE_SER);
      serial_port_enable <= read_on && (mode == ADCP_MODE_SER);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_buffer_enable <= 1'b0;
    end else begin
      ref_buffer_enable <= !ref_buffer_disable;
    end
  end

  // Reported as powered down only once no conversion is left running
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_down_active <= 1'b0;
    end else begin
      power_down_active <= power_down_in && !busy_next;
    end
  end

endmodule : adcp_port
`default_nettype wire

/* File: dv/adcp_port_asserts.sv */
// Concurrent checks on the converter output port
`timescale 1ns/100ps
`default_nettype none
module adcp_port_asserts
  import adcp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reset_in,
  input wire logic convert_start_n,
  input wire logic power_down_in,
  input wire logic low_power_sel,
  input wire logic interface_mode_sel_lo,
  input wire logic interface_mode_sel_hi,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [RES_W-1:0] data_oe,
  input wire logic busy,
  input wire logic serial_port_enable
);
  logic [1:0] mode;
  logic rd_on;
  logic [7:0] busy_cnt;
  assign mode = {interface_mode_sel_hi, interface_mode_sel_lo};
  assign rd_on = !cs_n && !rd_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Saturates so a long FIFO stall cannot wrap back to a small count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt <= 8'h00;
    end else if (!busy) begin
      busy_cnt <= 8'h00;
    end else if (busy_cnt != 8'hFF) begin
      busy_cnt <= busy_cnt + 8'h01;
    end
  end
  a_fixed_lines: assert property (data_oe[17:14] == 4'hF)
    else $error("fixed bus lines not driven");
  a_start_busy: assert property (!convert_start_n && $past(convert_start_n)
    && $past(resetn) && !$past(reset_in) && !reset_in && !busy
    && !power_down_in && !low_power_sel |=> busy)
    else $error("start edge did not raise busy");
  a_busy_length: assert property ($fell(busy) && !$past(reset_in)
    |-> busy_cnt >= CONV_CYCLES + 1)
    else $error("busy fell before conversion time");
  a_reset_abort: assert property (reset_in |=> !busy)
    else $error("reset did not abort conversion");
  a_bus_float: assert property (cs_n || rd_n |=> data_oe == OE_FIXED)
    else $error("bus driven without read");
  a_read_p18: assert property (rd_on && mode == 2'h0 |=> data_oe == OE_ALL)
    else $error("18-bit read enable wrong");
  a_read_p16: assert property (rd_on && mode == 2'h1 |=> data_oe == OE_WORD)
    else $error("16-bit read enable wrong");
  a_read_p8: assert property (rd_on && mode == 2'h2 |=> data_oe == OE_BYTE)
    else $error("8-bit read enable wrong");
  a_serial_port: assert property (mode == 2'h3 |=> data_oe == OE_FIXED
    && serial_port_enable == $past(rd_on))
    else $error("serial mode enables wrong");
  a_pd_block: assert property (power_down_in && !busy && !low_power_sel
    |=> !busy)
    else $error("conversion started in power-down");
endmodule : adcp_port_asserts
`default_nettype wire

/* File: dv/adcp_host_model.sv */
// Host side model: bus pin resolution and result-ready counting
`timescale 1ns/100ps
`default_nettype none
module adcp_host_model
  import adcp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic host_oe,
  input wire logic [2:0] host_sel,
  input wire logic [RES_W-1:0] data_out,
  input wire logic [RES_W-1:0] data_oe,
  input wire logic busy,
  output logic [RES_W-1:0] pin_level,
  output logic [7:0] ready_cnt
);
  logic busy_q;
  logic flip_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'h0;
      flip_reg <= 1'h0;
      ready_cnt <= 8'h00;
    end else begin
      busy_q <= busy;
      flip_reg <= ~flip_reg;
      if (busy_q && !busy) begin
        ready_cnt <= ready_cnt + 8'h01;
      end
    end
  end
  // Lines nobody drives toggle, so a floating bus never passes as data
  always_comb begin
    for (int i = 0; i < RES_W; i++) begin
      if (data_oe[i]) begin
        pin_level[i] = data_out[i];
      end else if (i < 3 && host_oe) begin
        pin_level[i] = host_sel[2'(i)];
      end else begin
        pin_level[i] = flip_reg ^ i[0];
      end
    end
  end
endmodule : adcp_host_model
`default_nettype wire

/* File: dv/adcp_port_bench.sv */
// Self-checking bench for the converter output port
`timescale 1ns/100ps
`default_nettype none
module adcp_port_bench
  import adcp_pkg::*;
;
  localparam logic [RES_W-1:0] CODE_A = 18'h2A5C3;
  logic clk, resetn, reset_in, convert_start_n, power_down_in;
  logic ref_buffer_disable, low_power_sel, fast_mode_sel, cs_n, rd_n;
  logic interface_mode_sel_lo, interface_mode_sel_hi, host_oe;
  logic serial_ext_clk_sel, serial_ext_clk, busy, ref_buffer_enable;
  logic serial_clk_gated, serial_port_enable, power_down_active;
  logic [2:0] host_sel;
  logic [RES_W-1:0] sample_code, data_in, data_out, data_oe;
  logic [7:0] ready_cnt;
  logic [7:0] e [4];
  int fails;
  int total_checks;
  adcp_port u_dut (.clk, .resetn, .reset_in, .convert_start_n,
    .power_down_in, .ref_buffer_disable, .low_power_sel, .fast_mode_sel,
    .interface_mode_sel_lo, .interface_mode_sel_hi, .cs_n, .rd_n,
    .serial_ext_clk_sel, .serial_ext_clk, .sample_code, .data_in, .data_out,
    .data_oe, .busy, .ref_buffer_enable, .serial_clk_gated,
    .serial_port_enable, .power_down_active);
  adcp_host_model u_host (.clk, .resetn, .host_oe, .host_sel, .data_out,
    .data_oe, .busy, .pin_level(data_in), .ready_cnt);
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // -------------------------------------------------------------
  // Shared drivers and comparison
  // -------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [RES_W-1:0] got,
      input logic [RES_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wait_busy(input logic lvl, input int lim);
    int i;
    i = 0;
    while (busy !== lvl && i < lim) begin
      tick(1);
      i++;
    end
    check("busy", {17'h0, busy}, {17'h0, lvl});
  endtask : wait_busy
  task automatic conv(input logic [RES_W-1:0] code);
    sample_code = code;
    convert_start_n = 1'h0;
    wait_busy(1'h1, 4);
    convert_start_n = 1'h1;
  endtask : conv
  task automatic rd(input logic [1:0] mode, input logic [2:0] sel);
    {interface_mode_sel_hi, interface_mode_sel_lo} = mode;
    host_sel = sel;
    host_oe = mode != 2'h0;
    cs_n = 1'h0;
    rd_n = 1'h0;
    tick(2);
  endtask : rd
  task automatic rel;
    cs_n = 1'h1;
    rd_n = 1'h1;
    tick(2);
    check("float", data_oe, OE_FIXED);
  endtask : rel
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_refbuf;
    ref_buffer_disable = 1'h1;
    tick(2);
    check("buf_off", {17'h0, ref_buffer_enable}, 18'h00000);
    ref_buffer_disable = 1'h0;
    tick(2);
    check("buf_on", {17'h0, ref_buffer_enable}, 18'h00001);
  endtask : t_refbuf
  task automatic t_p18;
    int n;
    logic [7:0] r0;
    r0 = ready_cnt;
    conv(CODE_A);
    n = 1;
    while (busy === 1'h1 && n < 300) begin
      tick(1);
      n++;
    end
    check("busy_len", 18'(n - 1), 18'(CONV_CYCLES + 1));
    tick(4);
    check("ready", {10'h0, ready_cnt}, {10'h0, r0 + 8'h01});
    rd(2'h0, 3'h0);
    check("p18", data_out, CODE_A);
    check("p18_oe", data_oe, OE_ALL);
    rel();
  endtask : t_p18
  task automatic t_p16;
    rd(2'h1, 3'h1);
    check("p16_hi", data_out & OE_WORD, {CODE_A[17:2], 2'h0});
    check("p16_oe", data_oe, OE_WORD);
    host_sel = 3'h3;
    tick(2);
    check("p16_lo", data_out & OE_WORD, {14'h0, CODE_A[1:0], 2'h0});
    host_sel = 3'h0;
    tick(2);
    check("p16_2c", data_out & OE_WORD, {~CODE_A[17], CODE_A[16:2], 2'h0});
    rel();
  endtask : t_p16
  task automatic t_p8;
    e = '{CODE_A[17:10], CODE_A[9:2], {6'h0, CODE_A[1:0]}, {CODE_A[1:0], 6'h0}};
    for (int s = 0; s < 4; s++) begin
      rd(2'h2, {s[0], s[1], 1'h1});
      check("p8", data_out & OE_BYTE, {e[s], 10'h0});
      check("p8_oe", data_oe, OE_BYTE);
    end
    rel();
  endtask : t_p8
  task automatic t_ser;
    serial_ext_clk = 1'h1;
    rd(2'h3, 3'h1);
    check("ser_en", {17'h0, serial_port_enable}, 18'h00001);
    check("ser_oe", data_oe, OE_FIXED);
    check("sclk_on", {17'h0, serial_clk_gated}, 18'h00001);
    serial_ext_clk = 1'h0;
    tick(2);
    check("sclk_low", {17'h0, serial_clk_gated}, 18'h00000);
    serial_ext_clk = 1'h1;
    serial_ext_clk_sel = 1'h0;
    tick(2);
    check("sclk_int", {17'h0, serial_clk_gated}, 18'h00000);
    serial_ext_clk_sel = 1'h1;
    rel();
    check("sclk_off", {17'h0, serial_clk_gated}, 18'h00000);
    serial_ext_clk = 1'h0;
  endtask : t_ser
  task automatic t_abort;
    conv(18'h15A5A);
    tick(20);
    reset_in = 1'h1;
    tick(2);
    check("abort", {17'h0, busy}, 18'h00000);
    reset_in = 1'h0;
    tick(2);
    rd(2'h0, 3'h0);
    check("cleared", data_out, DATA_RESET);
    rel();
  endtask : t_abort
  task automatic t_pd;
    conv(18'h0F0F0);
    tick(10);
    power_down_in = 1'h1;
    wait_busy(1'h0, 200);
    tick(3);
    check("pd_act", {17'h0, power_down_active}, 18'h00001);
    convert_start_n = 1'h0;
    tick(5);
    check("pd_block", {17'h0, busy}, 18'h00000);
    convert_start_n = 1'h1;
    power_down_in = 1'h0;
    tick(2);
    check("pd_off", {17'h0, power_down_active}, 18'h00000);
  endtask : t_pd
  task automatic t_imp;
    low_power_sel = 1'h1;
    sample_code = 18'h3C3C3;
    convert_start_n = 1'h0;
    wait_busy(1'h1, 4);
    wait_busy(1'h0, 200);
    wait_busy(1'h1, ACQ_CYCLES + 4);
    convert_start_n = 1'h1;
    wait_busy(1'h0, 200);
    tick(ACQ_CYCLES + 4);
    // Fast select high leaves impulse mode: a held start must not restart
    fast_mode_sel = 1'h1;
    convert_start_n = 1'h0;
    wait_busy(1'h1, 4);
    wait_busy(1'h0, 200);
    tick(ACQ_CYCLES + 4);
    check("no_restart", {17'h0, busy}, 18'h00000);
    convert_start_n = 1'h1;
    fast_mode_sel = 1'h0;
    tick(2);
    low_power_sel = 1'h0;
  endtask : t_imp
  // Held read keeps the output word, so the FIFO fills and stalls busy
  task automatic t_fifo;
    rd(2'h0, 3'h0);
    for (int k = 1; k <= 9; k++) begin
      conv(18'h30000 + 18'(k));
      if (k < 9) begin
        wait_busy(1'h0, 200);
      end
    end
    tick(200);
    check("stall", {17'h0, busy}, 18'h00001);
    rel();
    wait_busy(1'h0, 20);
    // Seven words still queued drain one per edge before the newest shows
    tick(8);
    rd(2'h0, 3'h0);
    check("newest", data_out, 18'h30009);
    rel();
  endtask : t_fifo
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    {resetn, reset_in, power_down_in, ref_buffer_disable} = 4'h0;
    {low_power_sel, fast_mode_sel, interface_mode_sel_lo} = 3'h0;
    {interface_mode_sel_hi, host_oe, serial_ext_clk} = 3'h0;
    {convert_start_n, cs_n, rd_n, serial_ext_clk_sel} = 4'hF;
    host_sel = 3'h0;
    sample_code = 18'h00000;
    tick(3);
    resetn = 1'h1;
    tick(2);
    check("rst_oe", data_oe, OE_FIXED);
    t_refbuf();
    $display("refbuf done");
    t_p18();
    $display("p18 done");
    t_p16();
    $display("p16 done");
    t_p8();
    $display("p8 done");
    t_ser();
    $display("serial done");
    t_abort();
    $display("abort done");
    t_pd();
    $display("powerdown done");
    t_imp();
    $display("impulse done");
    t_fifo();
    $display("fifo done");
    test_done();
  end
  initial begin
    #60000;
    fails++;
    test_done();
  end
endmodule : adcp_port_bench
bind adcp_port adcp_port_asserts u_chk (.clk, .resetn, .reset_in,
  .convert_start_n, .power_down_in, .low_power_sel, .interface_mode_sel_lo,
  .interface_mode_sel_hi, .cs_n, .rd_n, .data_oe, .busy,
  .serial_port_enable);
`default_nettype wire
